// ==== rtl/pos_out_pkg.sv ====
// shared constants for the position output and network state logic
package pos_out_pkg;
    localparam int CLK_MHZ = 20;
    // power-up time in microseconds; plain default
    localparam int POWERUP_US = 2000;
    localparam logic [15:0] FAULT_VALUE = 16'hFFFF;
    localparam logic [15:0] ZERO_NOM = 16'h012C;
    localparam logic [15:0] ZERO_MIN = 16'h0113;
    localparam logic [15:0] ZERO_MAX = 16'h0145;
    localparam logic [15:0] END_MAX = 16'h0FB9;
    localparam logic [2:0] CMD_NONE = 3'h0;
    localparam logic [2:0] CMD_START = 3'h1;
    localparam logic [2:0] CMD_STOP = 3'h2;
    localparam logic [2:0] CMD_PREOP = 3'h3;
    localparam logic [2:0] CMD_RST_NODE = 3'h4;
    localparam logic [2:0] CMD_RST_COMM = 3'h5;
    localparam logic [6:0] GS_BOOT = 7'h00;
    localparam logic [6:0] GS_STOP = 7'h04;
    localparam logic [6:0] GS_OP = 7'h05;
    localparam logic [6:0] GS_PREOP = 7'h7F;
    localparam logic [2:0] K_BOOT = 3'h0;
    localparam logic [2:0] K_PDO = 3'h1;
    localparam logic [2:0] K_SYNC = 3'h2;
    localparam logic [2:0] K_EMCY = 3'h3;
    localparam logic [2:0] K_GUARD = 3'h4;
    localparam logic [2:0] K_SDO = 3'h5;
    localparam logic [2:0] K_ADDR = 3'h6;
    localparam logic [1:0] CFG_ZERO = 2'h0;
    localparam logic [1:0] CFG_SAVE = 2'h1;
    localparam logic [15:0] SDO_OK = 16'h0000;
    localparam logic [15:0] SDO_BAD = 16'h0001;
    localparam int MSG_W = 35;
    localparam int FIFO_DEPTH = 4;
    typedef enum logic [1:0] {ST_INIT, ST_PREOP, ST_OP, ST_STOP} net_state_e;
endpackage

// ==== rtl/msg_fifo.sv ====
// small message fifo with valid/ready on both sides
`timescale 1ns/10ps
module msg_fifo #(
    parameter int W = 35,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic full;
    logic empty;
    // depth must be a power of two
    assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign empty = (wr_q == rd_q);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_q[rd_q[AW-1:0]];
    always_ff @(posedge clk) begin
        if (in_valid && !full) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_q <= '0;
        end else if (in_valid && !full) begin
            wr_q <= wr_q + {{AW{1'h0}}, 1'h1};
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_q <= '0;
        end else if (out_ready && !empty) begin
            rd_q <= rd_q + {{AW{1'h0}}, 1'h1};
        end
    end
endmodule

// ==== rtl/position_output_and_bus_state.sv ====
// position output, fault substitution and network state of the encoder
//
// Contract
// - during power-up the output value carries no valid position
// - boot message at power-up; while faulted position reads FFFF
// - missing magnet, null/cushion zone or element failure means fault
// - after power-up report position, switch to fault output on fault
// - four network states, changed by controller commands
// - initialization restores the last saved configuration
// - pre-operational state accepts configuration writes
// - operational state transmits position data
// - stopped state transmits no data and waits for commands
// - value spans 4000 digits, zero 275..325, end at most 4025
// - protocol is fixed per variant, canopen or j1939
// - j1939 variant takes its address and becomes operable by itself
// - process data with position and speed only when operational
// - parameter services served only in pre-operational or operational
// - synchronous process data sent after each sync object
// - node guard request answered with current network state
`timescale 1ns/10ps
module position_output_and_bus_state #(
    parameter int POWERUP_CYC = pos_out_pkg::POWERUP_US * pos_out_pkg::CLK_MHZ
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic variant_j1939,
    input wire logic [15:0] nv_zero,
    input wire logic [7:0] pref_addr,
    input wire logic magnet_missing,
    input wire logic magnet_in_null_zone,
    input wire logic element_failed,
    input wire logic sample_valid,
    input wire logic [15:0] sample_raw,
    input wire logic [2:0] nmt_cmd,
    input wire logic sync_pulse,
    input wire logic guard_req,
    input wire logic cfg_wr_valid,
    input wire logic [1:0] cfg_wr_addr,
    input wire logic [15:0] cfg_wr_data,
    input wire logic msg_ready,
    output logic msg_valid,
    output logic [2:0] msg_kind,
    output logic [15:0] msg_data,
    output logic [15:0] msg_aux,
    output logic [15:0] pos_value,
    output logic pos_valid,
    output logic fault,
    output logic [6:0] net_code,
    output logic [7:0] node_addr,
    output logic nv_save,
    output logic [15:0] nv_save_data,
    output logic proto_j1939
);
    pos_out_pkg::net_state_e state_q;
    logic cap_q;
    logic proto_q;
    logic [23:0] pu_cnt_q;
    logic pu_done;
    logic [2:0] f1_q;
    logic [2:0] f2_q;
    logic [2:0] f3_q;
    logic [2:0] fbits_q;
    logic fault_any;
    logic fault_q;
    logic [15:0] zero_q;
    logic [15:0] pos_q;
    logic pos_valid_q;
    logic [15:0] last_raw_q;
    logic [15:0] speed_q;
    logic [7:0] addr_q;
    logic toggle_q;
    logic [15:0] sdo_data_q;
    logic [15:0] sdo_stat_q;
    logic nv_save_q;
    logic [15:0] nv_save_data_q;
    logic [6:0] net_code_q;
    logic pend_boot_q;
    logic pend_emcy_q;
    logic pend_guard_q;
    logic pend_sync_q;
    logic pend_pdo_q;
    logic pend_sdo_q;
    logic live;
    logic cmd_ok;
    logic flush;
    logic flush_pd;
    logic sdo_take;
    logic sdo_good;
    logic push_v;
    logic [2:0] push_k;
    logic [15:0] push_d;
    logic [15:0] push_a;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [pos_out_pkg::MSG_W-1:0] fifo_out_data;
    logic msg_valid_q;
    logic [pos_out_pkg::MSG_W-1:0] msg_q;

    function automatic logic zero_in_range(input logic [15:0] v);
        return (v >= pos_out_pkg::ZERO_MIN) && (v <= pos_out_pkg::ZERO_MAX);
    endfunction

    function automatic logic [6:0] guard_code(input pos_out_pkg::net_state_e s);
        logic [6:0] c;
        c = pos_out_pkg::GS_BOOT;
        unique case (s)
            pos_out_pkg::ST_INIT: c = pos_out_pkg::GS_BOOT;
            pos_out_pkg::ST_PREOP: c = pos_out_pkg::GS_PREOP;
            pos_out_pkg::ST_OP: c = pos_out_pkg::GS_OP;
            pos_out_pkg::ST_STOP: c = pos_out_pkg::GS_STOP;
        endcase
        return c;
    endfunction

    function automatic logic [15:0] scale_pos(input logic [15:0] raw, input logic [15:0] z);
        logic [16:0] sum;
        sum = {1'h0, raw} + {1'h0, z};
        if (sum > {1'h0, pos_out_pkg::END_MAX}) begin
            return pos_out_pkg::END_MAX;
        end
        return sum[15:0];
    endfunction

    // variant strap caught once after reset release
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cap_q <= 1'h0;
            proto_q <= 1'h0;
        end else if (!cap_q) begin
            cap_q <= 1'h1;
            proto_q <= variant_j1939;
        end
    end

    // power-up timer
    assign pu_done = (state_q == pos_out_pkg::ST_INIT) && cap_q &&
                     (pu_cnt_q == 24'(POWERUP_CYC - 1));
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pu_cnt_q <= '0;
        end else if (state_q != pos_out_pkg::ST_INIT) begin
            pu_cnt_q <= '0;
        end else if (cap_q && !pu_done) begin
            pu_cnt_q <= pu_cnt_q + 24'h000001;
        end
    end

    // network state machine
    assign live = (state_q == pos_out_pkg::ST_PREOP) || (state_q == pos_out_pkg::ST_OP);
    assign cmd_ok = !proto_q && (state_q != pos_out_pkg::ST_INIT) &&
                    (nmt_cmd != pos_out_pkg::CMD_NONE);
    assign flush = cmd_ok && (nmt_cmd != pos_out_pkg::CMD_START) &&
                   (nmt_cmd != pos_out_pkg::CMD_PREOP);
    assign flush_pd = cmd_ok && (nmt_cmd != pos_out_pkg::CMD_START);
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= pos_out_pkg::ST_INIT;
        end else if (pu_done) begin
            state_q <= proto_q ? pos_out_pkg::ST_OP : pos_out_pkg::ST_PREOP;
        end else if (cmd_ok) begin
            unique case (nmt_cmd)
                pos_out_pkg::CMD_START: state_q <= pos_out_pkg::ST_OP;
                pos_out_pkg::CMD_STOP: state_q <= pos_out_pkg::ST_STOP;
                pos_out_pkg::CMD_PREOP: state_q <= pos_out_pkg::ST_PREOP;
                pos_out_pkg::CMD_RST_NODE: state_q <= pos_out_pkg::ST_INIT;
                pos_out_pkg::CMD_RST_COMM: state_q <= pos_out_pkg::ST_INIT;
                default: state_q <= state_q;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            net_code_q <= pos_out_pkg::GS_BOOT;
        end else begin
            net_code_q <= guard_code(state_q);
        end
    end

    // fault pin synchronisers, a bit changes once stages two and three agree
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            f1_q <= 3'h0;
            f2_q <= 3'h0;
            f3_q <= 3'h0;
            fbits_q <= 3'h0;
        end else begin
            f1_q <= {element_failed, magnet_in_null_zone, magnet_missing};
            f2_q <= f1_q;
            f3_q <= f2_q;
            fbits_q <= (f2_q & f3_q) | (fbits_q & (f2_q | f3_q));
        end
    end
    assign fault_any = |fbits_q;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fault_q <= 1'h0;
        end else begin
            fault_q <= fault_any;
        end
    end

    // zero point configuration
    assign sdo_take = cfg_wr_valid && !proto_q && live;
    assign sdo_good = (cfg_wr_addr == pos_out_pkg::CFG_ZERO) ? zero_in_range(cfg_wr_data) :
                      (cfg_wr_addr == pos_out_pkg::CFG_SAVE);
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            zero_q <= pos_out_pkg::ZERO_NOM;
        end else if (state_q == pos_out_pkg::ST_INIT) begin
            zero_q <= zero_in_range(nv_zero) ? nv_zero : pos_out_pkg::ZERO_NOM;
        end else if (sdo_take && sdo_good && (cfg_wr_addr == pos_out_pkg::CFG_ZERO)) begin
            zero_q <= cfg_wr_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            nv_save_q <= 1'h0;
            nv_save_data_q <= '0;
            sdo_data_q <= '0;
            sdo_stat_q <= pos_out_pkg::SDO_OK;
        end else begin
            nv_save_q <= sdo_take && (cfg_wr_addr == pos_out_pkg::CFG_SAVE);
            if (sdo_take && (cfg_wr_addr == pos_out_pkg::CFG_SAVE)) begin
                nv_save_data_q <= zero_q;
            end
            if (sdo_take) begin
                sdo_data_q <= cfg_wr_data;
                sdo_stat_q <= sdo_good ? pos_out_pkg::SDO_OK : pos_out_pkg::SDO_BAD;
            end
        end
    end

    // position value with fault substitution
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pos_q <= '0;
            pos_valid_q <= 1'h0;
        end else if (state_q == pos_out_pkg::ST_INIT) begin
            pos_q <= '0;
            pos_valid_q <= 1'h0;
        end else if (fault_any) begin
            pos_q <= pos_out_pkg::FAULT_VALUE;
            pos_valid_q <= 1'h0;
        end else if (sample_valid) begin
            pos_q <= scale_pos(sample_raw, zero_q);
            pos_valid_q <= 1'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            last_raw_q <= '0;
            speed_q <= '0;
        end else if (state_q == pos_out_pkg::ST_INIT) begin
            last_raw_q <= '0;
            speed_q <= '0;
        end else if (sample_valid) begin
            last_raw_q <= sample_raw;
            speed_q <= sample_raw - last_raw_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            addr_q <= '0;
        end else if (pu_done && proto_q) begin
            addr_q <= pref_addr;
        end
    end

    // message arbitration, highest pending first
    always_comb begin
        push_v = 1'h1;
        push_k = pos_out_pkg::K_BOOT;
        push_d = '0;
        push_a = '0;
        if (pend_boot_q) begin
            push_k = proto_q ? pos_out_pkg::K_ADDR : pos_out_pkg::K_BOOT;
            push_d = {8'h00, addr_q};
        end else if (pend_emcy_q) begin
            push_k = pos_out_pkg::K_EMCY;
            push_d = pos_out_pkg::FAULT_VALUE;
            push_a = {13'h0000, fbits_q};
        end else if (pend_guard_q) begin
            push_k = pos_out_pkg::K_GUARD;
            push_d = {8'h00, toggle_q, guard_code(state_q)};
        end else if (pend_sync_q) begin
            push_k = pos_out_pkg::K_SYNC;
            push_d = pos_q;
            push_a = speed_q;
        end else if (pend_pdo_q) begin
            push_k = pos_out_pkg::K_PDO;
            push_d = pos_q;
            push_a = speed_q;
        end else if (pend_sdo_q) begin
            push_k = pos_out_pkg::K_SDO;
            push_d = sdo_data_q;
            push_a = sdo_stat_q;
        end else begin
            push_v = 1'h0;
        end
    end

    // pending events; a new event wins over the take of an older one
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pend_boot_q <= 1'h0;
            pend_emcy_q <= 1'h0;
            pend_guard_q <= 1'h0;
            pend_sync_q <= 1'h0;
            pend_pdo_q <= 1'h0;
            pend_sdo_q <= 1'h0;
        end else begin
            pend_boot_q <= pu_done || (pend_boot_q && !fifo_in_ready);
            pend_emcy_q <= (fault_any && !fault_q && live) ||
                           (pend_emcy_q && !flush && !(fifo_in_ready && !pend_boot_q));
            pend_guard_q <= (guard_req && !proto_q && (state_q != pos_out_pkg::ST_INIT)) ||
                            (pend_guard_q && !(fifo_in_ready && push_k == pos_out_pkg::K_GUARD));
            pend_sync_q <= (sync_pulse && !proto_q && state_q == pos_out_pkg::ST_OP &&
                            !flush_pd) || (pend_sync_q && !flush_pd &&
                            !(fifo_in_ready && push_k == pos_out_pkg::K_SYNC));
            pend_pdo_q <= (sample_valid && state_q == pos_out_pkg::ST_OP && !flush_pd) ||
                          (pend_pdo_q && !flush_pd &&
                           !(fifo_in_ready && push_k == pos_out_pkg::K_PDO));
            pend_sdo_q <= sdo_take || (pend_sdo_q && !flush &&
                          !(fifo_in_ready && push_k == pos_out_pkg::K_SDO));
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            toggle_q <= 1'h0;
        end else if (state_q == pos_out_pkg::ST_INIT) begin
            toggle_q <= 1'h0;
        end else if (push_v && fifo_in_ready && push_k == pos_out_pkg::K_GUARD) begin
            toggle_q <= !toggle_q;
        end
    end

    msg_fifo #(
        .W(pos_out_pkg::MSG_W),
        .DEPTH(pos_out_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(core_clk),
        .rst_n(rst_n),
        .in_valid(push_v),
        .in_ready(fifo_in_ready),
        .in_data({push_k, push_d, push_a}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // registered output stage toward the can controller
    assign fifo_out_ready = !msg_valid_q || msg_ready;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            msg_valid_q <= 1'h0;
            msg_q <= '0;
        end else if (fifo_out_ready) begin
            msg_valid_q <= fifo_out_valid;
            if (fifo_out_valid) begin
                msg_q <= fifo_out_data;
            end
        end
    end

    assign msg_valid = msg_valid_q;
    assign msg_kind = msg_q[34:32];
    assign msg_data = msg_q[31:16];
    assign msg_aux = msg_q[15:0];
    assign pos_value = pos_q;
    assign pos_valid = pos_valid_q;
    assign fault = fault_q;
    assign net_code = net_code_q;
    assign node_addr = addr_q;
    assign nv_save = nv_save_q;
    assign nv_save_data = nv_save_data_q;
    assign proto_j1939 = proto_q;

    chk_init_no_pos: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_q == pos_out_pkg::ST_INIT) |=> !pos_valid_q && (pos_q == 16'h0000))
        else $error("position valid during power-up");
    chk_fault_value: assert property (@(posedge core_clk) disable iff (!rst_n)
        (fault_any && state_q != pos_out_pkg::ST_INIT) |=> (pos_q == 16'hFFFF))
        else $error("fault value not substituted");
    chk_fault_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
        (f2_q[0] && f3_q[0]) |-> ##2 fault_q)
        else $error("missing magnet did not raise fault");
    chk_pdo_only_op: assert property (@(posedge core_clk) disable iff (!rst_n)
        (push_v && push_k == pos_out_pkg::K_PDO && fifo_in_ready) |->
        $past(state_q) == pos_out_pkg::ST_OP || state_q == pos_out_pkg::ST_OP)
        else $error("process data outside operational");
    chk_stop_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_q == pos_out_pkg::ST_STOP && $past(state_q) == pos_out_pkg::ST_STOP) |->
        !pend_pdo_q && !pend_sync_q && !pend_sdo_q)
        else $error("data pending while stopped");
    chk_sdo_refused: assert property (@(posedge core_clk) disable iff (!rst_n)
        (cfg_wr_valid && state_q == pos_out_pkg::ST_STOP) |=> $stable(zero_q))
        else $error("configuration changed while stopped");
    chk_zero_range: assert property (@(posedge core_clk) disable iff (!rst_n)
        (zero_q >= 16'h0113) && (zero_q <= 16'h0145))
        else $error("zero point out of range");
    chk_pos_range: assert property (@(posedge core_clk) disable iff (!rst_n)
        pos_valid_q |-> (pos_q <= 16'h0FB9) && (pos_q >= 16'h0113))
        else $error("position outside span");
    chk_sync_pdo: assert property (@(posedge core_clk) disable iff (!rst_n)
        (sync_pulse && !proto_q && state_q == pos_out_pkg::ST_OP) |=> pend_sync_q)
        else $error("sync not followed by process data");
    chk_guard_reply: assert property (@(posedge core_clk) disable iff (!rst_n)
        (guard_req && !proto_q && state_q != pos_out_pkg::ST_INIT) |=> pend_guard_q)
        else $error("guard request not answered");
    chk_proto_fixed: assert property (@(posedge core_clk) disable iff (!rst_n)
        cap_q |=> $stable(proto_q))
        else $error("protocol changed after capture");
    chk_j1939_op: assert property (@(posedge core_clk) disable iff (!rst_n)
        (pu_done && proto_q) |=> (state_q == pos_out_pkg::ST_OP) && (addr_q == $past(pref_addr)))
        else $error("j1939 variant not operable after power-up");
    chk_nmt_start: assert property (@(posedge core_clk) disable iff (!rst_n)
        (cmd_ok && nmt_cmd == pos_out_pkg::CMD_START && !pu_done) |=>
        (state_q == pos_out_pkg::ST_OP))
        else $error("start command ignored");
endmodule

// ==== dv/bus_master_model.sv ====
// controller model: takes messages from the encoder, slowly or stalled
`timescale 1ns/10ps
module bus_master_model (
    input wire logic core_clk,
    input wire logic hold,
    input wire logic msg_valid,
    input wire logic [2:0] msg_kind,
    input wire logic [15:0] msg_data,
    input wire logic [15:0] msg_aux,
    output logic msg_ready
);
    int n_msg = 0;
    logic [2:0] last_kind = 3'h0;
    logic [15:0] last_data = 16'h0000;
    logic [15:0] last_aux = 16'h0000;
    logic lim_bad = 1'b0;
    logic ph = 1'b0;
    // takes every other cycle; hold stops taking altogether
    assign msg_ready = !hold && !ph;
    always @(posedge core_clk) begin
        ph <= !ph;
        if (msg_valid && msg_ready) begin
            n_msg <= n_msg + 1;
            last_kind <= msg_kind;
            last_data <= msg_data;
            last_aux <= msg_aux;
            // boot and fault values are status, never used as position
            // position limits keep the 25 digit margin
            if (msg_kind == pos_out_pkg::K_PDO && msg_data != pos_out_pkg::FAULT_VALUE &&
                (msg_data < pos_out_pkg::ZERO_MIN || msg_data > pos_out_pkg::END_MAX)) begin
                lim_bad <= 1'b1;
            end
        end
    end
endmodule

// ==== dv/testbench.sv ====
// self-checking bench for the position output and network state block
`timescale 1ns/10ps
module testbench;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic variant_j1939 = 1'b0;
    logic [15:0] nv_zero, sample_raw = 16'h0000, cfg_wr_data = 16'h0000;
    logic [7:0] pref_addr = 8'h00;
    logic [2:0] pins = 3'h0, nmt_cmd = 3'h0;
    logic sample_valid = 1'b0, sync_pulse = 1'b0, guard_req = 1'b0, cfg_wr_valid = 1'b0;
    logic [1:0] cfg_wr_addr = 2'h0;
    logic hold = 1'b0, msg_ready, msg_valid, fault, pos_valid, nv_save, proto_j1939;
    logic [2:0] msg_kind;
    logic [15:0] msg_data, msg_aux, pos_value, nv_save_data, r;
    logic [6:0] net_code;
    logic [7:0] node_addr;
    logic [31:0] seed = 32'h1FDD713B;
    int num_errors = 0, n_compared = 0, mark = 0, cyc = 0;
    always #25 core_clk = ~core_clk;
    position_output_and_bus_state #(.POWERUP_CYC(20)) position_output_and_bus_state_i (
        .core_clk(core_clk), .rst_n(rst_n), .variant_j1939(variant_j1939),
        .nv_zero(nv_zero), .pref_addr(pref_addr), .magnet_missing(pins[0]),
        .magnet_in_null_zone(pins[1]), .element_failed(pins[2]),
        .sample_valid(sample_valid), .sample_raw(sample_raw), .nmt_cmd(nmt_cmd),
        .sync_pulse(sync_pulse), .guard_req(guard_req), .cfg_wr_valid(cfg_wr_valid),
        .cfg_wr_addr(cfg_wr_addr), .cfg_wr_data(cfg_wr_data), .msg_ready(msg_ready),
        .msg_valid(msg_valid), .msg_kind(msg_kind), .msg_data(msg_data), .msg_aux(msg_aux),
        .pos_value(pos_value), .pos_valid(pos_valid), .fault(fault), .net_code(net_code),
        .node_addr(node_addr), .nv_save(nv_save), .nv_save_data(nv_save_data),
        .proto_j1939(proto_j1939));
    bus_master_model bus_master_model_i (.core_clk(core_clk), .hold(hold),
        .msg_valid(msg_valid), .msg_kind(msg_kind), .msg_data(msg_data),
        .msg_aux(msg_aux), .msg_ready(msg_ready));
    function automatic logic [31:0] nxt();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] exp_pos(input logic [15:0] raw, input logic [15:0] z);
        logic [16:0] s;
        s = {1'b0, raw} + {1'b0, z};
        return (s > {1'b0, pos_out_pkg::END_MAX}) ? pos_out_pkg::END_MAX : s[15:0];
    endfunction
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task automatic waitn(input int n);
        for (int i = 0; i < 80 && bus_master_model_i.n_msg < mark + n; i++) tick(1);
        chk("msg count", 16'(bus_master_model_i.n_msg - mark), 16'(n));
        mark = bus_master_model_i.n_msg;
    endtask
    task automatic take(input logic [2:0] k, input logic [15:0] d, input logic [15:0] a,
                        input logic [1:0] m);
        waitn(1);
        chk("msg kind", {13'h0, bus_master_model_i.last_kind}, {13'h0, k});
        if (m[0]) chk("msg data", bus_master_model_i.last_data, d);
        if (m[1]) chk("msg aux", bus_master_model_i.last_aux, a);
    endtask
    task automatic quiet();
        tick(20);
        waitn(0);
    endtask
    task automatic cmd(input logic [2:0] c);
        nmt_cmd = c;
        tick(1);
        nmt_cmd = 3'h0;
        tick(3);
    endtask
    task automatic cfg(input logic [1:0] a, input logic [15:0] d);
        cfg_wr_addr = a;
        cfg_wr_data = d;
        pulse(cfg_wr_valid);
    endtask
    task automatic smp(input logic [15:0] v);
        sample_raw = v;
        pulse(sample_valid);
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        nv_zero = pos_out_pkg::ZERO_MIN + 16'(nxt() % 51);
        tick(2);
        rst_n = 1'b1;
        tick(5);
        chk("pos init", pos_value, 16'h0000);
        chk("code init", {9'h0, net_code}, {9'h0, pos_out_pkg::GS_BOOT});
        take(pos_out_pkg::K_BOOT, 16'h0000, 16'h0000, 2'h0);
        chk("code preop", {9'h0, net_code}, {9'h0, pos_out_pkg::GS_PREOP});
        smp(16'h0010);
        quiet();
        cfg(pos_out_pkg::CFG_ZERO, pos_out_pkg::ZERO_MIN);
        take(pos_out_pkg::K_SDO, pos_out_pkg::ZERO_MIN, pos_out_pkg::SDO_OK, 2'h3);
        cfg(pos_out_pkg::CFG_ZERO, pos_out_pkg::ZERO_MIN - 16'h1);
        take(pos_out_pkg::K_SDO, pos_out_pkg::ZERO_MIN - 16'h1, pos_out_pkg::SDO_BAD, 2'h3);
        cfg(pos_out_pkg::CFG_SAVE, 16'h0000);
        take(pos_out_pkg::K_SDO, 16'h0000, pos_out_pkg::SDO_OK, 2'h2);
        chk("saved zero", nv_save_data, pos_out_pkg::ZERO_MIN);
        $display("test preop done");
        cmd(pos_out_pkg::CMD_START);
        chk("code op", {9'h0, net_code}, {9'h0, pos_out_pkg::GS_OP});
        for (int i = 0; i < 12; i++) begin
            r = (i == 0) ? 16'h0EA6 : (i == 1) ? 16'h0EA7 : 16'(nxt() % 32'hF00);
            smp(r);
            take(pos_out_pkg::K_PDO, exp_pos(r, pos_out_pkg::ZERO_MIN), 16'h1, {i == 1, 1'b1});
            chk("pos valid", {15'h0, pos_valid}, 16'h0001);
            chk("pos", pos_value, exp_pos(r, pos_out_pkg::ZERO_MIN));
        end
        pulse(sync_pulse);
        take(pos_out_pkg::K_SYNC, exp_pos(r, pos_out_pkg::ZERO_MIN), 16'h0, 2'h1);
        pulse(guard_req);
        take(pos_out_pkg::K_GUARD, {9'h0, pos_out_pkg::GS_OP}, 16'h0, 2'h1);
        for (int j = 0; j < 3; j++) begin
            pins = 3'h1 << j;
            take(pos_out_pkg::K_EMCY, pos_out_pkg::FAULT_VALUE, 16'(pins), 2'h3);
            chk("pos fault", pos_value, pos_out_pkg::FAULT_VALUE);
            pins = 3'h0;
            tick(8);
            chk("fault clear", {15'h0, fault}, 16'h0000);
        end
        $display("test operational done");
        hold = 1'b1;
        pulse(guard_req);
        pulse(sync_pulse);
        smp(16'h0020);
        cfg(pos_out_pkg::CFG_ZERO, pos_out_pkg::ZERO_NOM);
        pins = 3'h4;
        tick(15);
        chk("held valid", {15'h0, msg_valid}, 16'h0001);
        hold = 1'b0;
        waitn(5);
        pins = 3'h0;
        tick(10);
        $display("test buffer done");
        cmd(pos_out_pkg::CMD_STOP);
        chk("code stop", {9'h0, net_code}, {9'h0, pos_out_pkg::GS_STOP});
        smp(16'h0007);
        cfg(pos_out_pkg::CFG_ZERO, pos_out_pkg::ZERO_NOM);
        pulse(sync_pulse);
        quiet();
        pulse(guard_req);
        take(pos_out_pkg::K_GUARD, {9'h0, pos_out_pkg::GS_STOP}, 16'h0, 2'h1);
        cmd(pos_out_pkg::CMD_RST_NODE);
        chk("code reset", {9'h0, net_code}, {9'h0, pos_out_pkg::GS_BOOT});
        take(pos_out_pkg::K_BOOT, 16'h0000, 16'h0000, 2'h0);
        cmd(pos_out_pkg::CMD_START);
        smp(16'h0100);
        take(pos_out_pkg::K_PDO, exp_pos(16'h0100, nv_zero), 16'h0, 2'h1);
        $display("test stop and reset done");
        variant_j1939 = 1'b1;
        pref_addr = nxt() % 8'hFF;
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        take(pos_out_pkg::K_ADDR, 16'h0000, 16'h0000, 2'h0);
        chk("addr", {8'h0, node_addr}, {8'h0, pref_addr});
        chk("proto", {15'h0, proto_j1939}, 16'h0001);
        cmd(pos_out_pkg::CMD_STOP);
        chk("code j1939", {9'h0, net_code}, {9'h0, pos_out_pkg::GS_OP});
        chk("limits", {15'h0, bus_master_model_i.lim_bad}, 16'h0000);
        $display("test j1939 done");
        conclude();
    end
endmodule
